// ### rtl/ssf_top.sv
// two-wire slave front end: pin filters, byte engine, timeout, power-up
// Behaviour
// RL1 - sample on rising, change after falling
// RL2 - count clock-low only inside a transaction
// RL3 - timeout resets interface and releases data
// RL4 - reject pulses of 50 ns or less
// RL5 - data driven low only, released for one
// RL6 - master clock at most 1 MHz
// RL7 - master makes clock, start, stop
// RL8 - respond only when select bits match pins
// RL9 - unconnected select pins read as zero
// RL10 - sensor converts, memory standby after power-up
// RL11 - power loss resets everything cleanly
// RL12 - first temperature valid within 100 ms
// RL13 - alert output open-drain and configurable
// RL14 - host applies high voltage for protect
// RL15 - address: preamble, select bits, read/write bit
// RL16 - receiver acknowledges each byte on ninth clock; a written byte is not acked while the buffer is full
// RL17 - stop transmitting after no-ack then stop
// RL18 - after timeout ignore bus until start
`timescale 1ns/10ps
module ssf_top #(
	parameter logic [ssf_pkg::SSF_TMO_W-1:0] TMO_CYCLES = ssf_pkg::SSF_TMO_DEF,
	parameter logic [ssf_pkg::SSF_PU_W-1:0]  PU_CYCLES  = ssf_pkg::SSF_PU_DEF
) (
	// clock, enable and power-on reset
	input  wire logic                             clock,
	input  wire logic                             ce,
	input  wire logic                             rst,
	// serial bus pins
	input  wire logic                             scl_in,
	input  wire logic                             sda_in,
	output logic                                  sda_out,
	output logic                                  sda_oe,
	// address-select pins
	input  wire logic                             sel_pin0,
	input  wire logic                             sel_pin1,
	input  wire logic                             sel_pin2,
	// alert pin and its control
	input  wire logic                             alert_cond,
	input  wire logic                             alert_en,
	output logic                                  alert_out,
	output logic                                  alert_oe,
	// transmit byte source
	input  wire logic [ssf_pkg::SSF_FIFO_W-1:0]   tx_data,
	output logic                                  tx_req,
	// received byte stream
	output logic [ssf_pkg::SSF_FIFO_W-1:0]        rx_data,
	output logic                                  rx_valid,
	input  wire logic                             rx_ready,
	// transaction status
	output logic                                  addr_ts,
	output logic                                  addr_mem,
	output logic                                  read_mode,
	output logic                                  start_seen,
	output logic                                  stop_seen,
	output logic                                  timeout,
	// power-up state of the two parts
	output logic                                  ts_convert,
	output logic                                  mem_standby,
	output logic                                  temp_valid
);
	import ssf_pkg::*;

	// filtered pin levels and their previous values
	logic                 scl_f;
	logic                 sda_f;
	logic                 scl_d_r;
	logic                 sda_d_r;
	logic [2:0]           sel_level;

	// decoded bus events
	logic                 scl_rise;
	logic                 scl_fall;
	logic                 start_c;
	logic                 stop_c;
	logic                 tmo_c;
	logic                 byte_end;
	logic                 addr_hit;

	// byte engine
	ssf_state_type        state_r;
	logic [3:0]           bitcnt_r;
	logic [SSF_MSB:0]     shift_r;
	logic                 sda_oe_r;
	logic                 in_txn_r;
	logic [SSF_TMO_W-1:0] lowcnt_r;

	// user side and status registers
	logic                 push_r;
	logic [SSF_MSB:0]     push_data_r;
	logic                 tx_req_r;
	logic [SSF_MSB:0]     rx_data_r;
	logic                 rx_valid_r;
	logic                 addr_ts_r;
	logic                 addr_mem_r;
	logic                 read_mode_r;
	logic                 start_r;
	logic                 stop_r;
	logic                 tmo_r;
	logic [SSF_PU_W-1:0]  pu_cnt_r;
	logic                 temp_valid_r;
	logic                 ts_convert_r;
	logic                 mem_standby_r;
	logic                 alert_oe_r;
	logic                 pin_low_r;

	// buffer carriers
	ssf_stream_if #(.W(SSF_FIFO_W)) fill_if ();
	ssf_stream_if #(.W(SSF_FIFO_W)) drain_if ();

	// RL4 filter clock and data inputs
	ssf_filt #(.HOLD(SSF_HOLD_CYC), .RST_VAL(SSF_BUS_IDLE)) u_scl (
		.clock (clock),
		.ce    (ce),
		.rst   (rst),
		.pin   (scl_in),
		.level (scl_f)
	);
	ssf_filt #(.HOLD(SSF_HOLD_CYC), .RST_VAL(SSF_BUS_IDLE)) u_sda (
		.clock (clock),
		.ce    (ce),
		.rst   (rst),
		.pin   (sda_in),
		.level (sda_f)
	);

	// RL9 select pins start as zero
	ssf_filt #(.HOLD(SSF_HOLD_CYC), .RST_VAL(SSF_SEL_RST)) u_sel0 (
		.clock (clock),
		.ce    (ce),
		.rst   (rst),
		.pin   (sel_pin0),
		.level (sel_level[0])
	);
	ssf_filt #(.HOLD(SSF_HOLD_CYC), .RST_VAL(SSF_SEL_RST)) u_sel1 (
		.clock (clock),
		.ce    (ce),
		.rst   (rst),
		.pin   (sel_pin1),
		.level (sel_level[1])
	);
	ssf_filt #(.HOLD(SSF_HOLD_CYC), .RST_VAL(SSF_SEL_RST)) u_sel2 (
		.clock (clock),
		.ce    (ce),
		.rst   (rst),
		.pin   (sel_pin2),
		.level (sel_level[2])
	);

	// received bytes wait here until the user takes them
	ssf_fifo #(.WIDTH(SSF_FIFO_W), .DEPTH(SSF_FIFO_D)) u_fifo (
		.clock (clock),
		.ce    (ce),
		.rst   (rst),
		.wr    (fill_if.snk),
		.rd    (drain_if.src)
	);

	// edge and condition decode; the device only listens to the clock
	// RL7 start and stop come from the master
	assign scl_rise = scl_f && !scl_d_r;
	assign scl_fall = !scl_f && scl_d_r;
	assign start_c  = scl_f && scl_d_r && sda_d_r && !sda_f;
	assign stop_c   = scl_f && scl_d_r && !sda_d_r && sda_f;
	assign byte_end = scl_fall && bitcnt_r == SSF_BYTE_BITS;
	// RL3 clock held low too long
	assign tmo_c    = in_txn_r && !scl_f && lowcnt_r == TMO_CYCLES - 1'b1;
	// RL8 RL15 preamble and select match
	assign addr_hit = (shift_r[SSF_PRE_HI:SSF_PRE_LO] == SSF_PRE_TS ||
		shift_r[SSF_PRE_HI:SSF_PRE_LO] == SSF_PRE_MEM) &&
		shift_r[SSF_SEL_HI:SSF_SEL_LO] == sel_level;

	// buffer hookups
	assign fill_if.valid  = push_r;
	assign fill_if.data   = push_data_r;
	assign drain_if.ready = !rx_valid_r || rx_ready;

	// outputs straight from flip-flops
	assign sda_out     = pin_low_r;
	assign sda_oe      = sda_oe_r;
	assign alert_out   = pin_low_r;
	assign alert_oe    = alert_oe_r;
	assign tx_req      = tx_req_r;
	assign rx_data     = rx_data_r;
	assign rx_valid    = rx_valid_r;
	assign addr_ts     = addr_ts_r;
	assign addr_mem    = addr_mem_r;
	assign read_mode   = read_mode_r;
	assign start_seen  = start_r;
	assign stop_seen   = stop_r;
	assign timeout     = tmo_r;
	assign ts_convert  = ts_convert_r;
	assign mem_standby = mem_standby_r;
	assign temp_valid  = temp_valid_r;

	// previous filtered levels for edge detection
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_d_r <= SSF_BUS_IDLE;
			sda_d_r <= SSF_BUS_IDLE;
		end else if (ce) begin
			scl_d_r <= scl_f;
			sda_d_r <= sda_f;
		end
	end

	// RL2 transaction window between start and stop
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in_txn_r <= 1'b0;
		end else if (ce) begin
			if (start_c) begin
				in_txn_r <= 1'b1;
			end else if (stop_c || tmo_c) begin
				in_txn_r <= 1'b0;
			end
		end
	end

	// RL2 clock-low counter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lowcnt_r <= '0;
		end else if (ce) begin
			if (!in_txn_r || scl_f) begin
				lowcnt_r <= '0;
			end else if (lowcnt_r != TMO_CYCLES) begin
				lowcnt_r <= lowcnt_r + 1'b1;
			end
		end
	end

	// byte engine: state, bit count, shifter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r  <= SSF_IDLE;
			bitcnt_r <= '0;
			shift_r  <= '0;
		end else if (ce) begin
			// RL3 RL18 timeout drops to idle until start
			if (tmo_c) begin
				state_r <= SSF_IDLE;
			end else if (start_c) begin
				state_r  <= SSF_ADDR;
				bitcnt_r <= '0;
			end else if (stop_c) begin
				state_r <= SSF_IDLE;
			end else begin
				case (state_r)
					SSF_ADDR, SSF_WRITE: begin
						// RL1 sample on rising edge
						if (scl_rise && bitcnt_r != SSF_BYTE_BITS) begin
							shift_r  <= {shift_r[SSF_NEXT:0], sda_f};
							bitcnt_r <= bitcnt_r + 1'b1;
						end else if (byte_end) begin
							if (state_r == SSF_WRITE) begin
								state_r <= SSF_ACKW;
							end else if (addr_hit) begin
								state_r <= SSF_ACKA;
							end else begin
								state_r <= SSF_WAIT;
							end
						end
					end
					SSF_ACKA: begin
						// leave address acknowledge
						if (scl_fall && shift_r[SSF_RW_BIT]) begin
							state_r  <= SSF_READ;
							shift_r  <= tx_data;
							bitcnt_r <= 4'h1;
						end else if (scl_fall) begin
							state_r  <= SSF_WRITE;
							bitcnt_r <= '0;
						end
					end
					SSF_ACKW: begin
						// next written byte
						if (scl_fall) begin
							state_r  <= SSF_WRITE;
							bitcnt_r <= '0;
						end
					end
					SSF_READ: begin
						// shift out after falling edge
						if (scl_fall && bitcnt_r != SSF_BYTE_BITS) begin
							shift_r  <= {shift_r[SSF_NEXT:0], 1'b0};
							bitcnt_r <= bitcnt_r + 1'b1;
						end else if (scl_fall) begin
							state_r <= SSF_ACKR;
						end
					end
					SSF_ACKR: begin
						// RL17 no-ack ends transmission
						if (scl_rise && sda_f) begin
							state_r <= SSF_WAIT;
						end else if (scl_fall) begin
							state_r  <= SSF_READ;
							shift_r  <= tx_data;
							bitcnt_r <= 4'h1;
						end
					end
					default: begin
						state_r <= state_r;
					end
				endcase
			end
		end
	end

	// RL5 RL16 open-drain data drive
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sda_oe_r <= 1'b0;
		end else if (ce) begin
			if (tmo_c || start_c || stop_c) begin
				sda_oe_r <= 1'b0;
			end else if (scl_fall) begin
				case (state_r)
					SSF_ADDR:  sda_oe_r <= byte_end && addr_hit;
					SSF_WRITE: sda_oe_r <= byte_end && fill_if.ready;
					SSF_ACKA:  sda_oe_r <= shift_r[SSF_RW_BIT] && !tx_data[SSF_MSB];
					SSF_READ:  sda_oe_r <= !byte_end && !shift_r[SSF_NEXT];
					SSF_ACKR:  sda_oe_r <= !tx_data[SSF_MSB];
					default:   sda_oe_r <= 1'b0;
				endcase
			end
		end
	end

	// RL16 written byte into buffer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			push_r      <= 1'b0;
			push_data_r <= '0;
			tx_req_r    <= 1'b0;
		end else if (ce) begin
			push_r   <= state_r == SSF_WRITE && byte_end && fill_if.ready &&
				!start_c && !stop_c;
			push_data_r <= shift_r;
			tx_req_r <= scl_fall && !tmo_c && !start_c && !stop_c &&
				((state_r == SSF_ACKA && shift_r[SSF_RW_BIT]) ||
				state_r == SSF_ACKR);
		end
	end

	// output register of the receive stream
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_valid_r <= 1'b0;
			rx_data_r  <= '0;
		end else if (ce) begin
			if (drain_if.valid && drain_if.ready) begin
				rx_valid_r <= 1'b1;
				rx_data_r  <= drain_if.data;
			end else if (rx_ready) begin
				rx_valid_r <= 1'b0;
			end
		end
	end

	// RL15 which part was addressed
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addr_ts_r   <= 1'b0;
			addr_mem_r  <= 1'b0;
			read_mode_r <= 1'b0;
		end else if (ce) begin
			if (stop_c || tmo_c || start_c) begin
				addr_ts_r  <= 1'b0;
				addr_mem_r <= 1'b0;
			end else if (state_r == SSF_ADDR && byte_end && addr_hit) begin
				addr_ts_r   <= shift_r[SSF_PRE_HI:SSF_PRE_LO] == SSF_PRE_TS;
				addr_mem_r  <= shift_r[SSF_PRE_HI:SSF_PRE_LO] == SSF_PRE_MEM;
				read_mode_r <= shift_r[SSF_RW_BIT];
			end
		end
	end

	// one-cycle bus event pulses
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			start_r <= 1'b0;
			stop_r  <= 1'b0;
			tmo_r   <= 1'b0;
		end else if (ce) begin
			start_r <= start_c;
			stop_r  <= stop_c;
			tmo_r   <= tmo_c;
		end
	end

	// RL10 RL11 RL12 power-up state of the parts
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pu_cnt_r      <= '0;
			temp_valid_r  <= 1'b0;
			ts_convert_r  <= 1'b1;
			mem_standby_r <= 1'b1;
		end else if (ce) begin
			if (pu_cnt_r == PU_CYCLES - 1'b1) begin
				temp_valid_r <= 1'b1;
			end else begin
				pu_cnt_r <= pu_cnt_r + 1'b1;
			end
		end
	end

	// RL13 alert pin, open-drain
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			alert_oe_r <= 1'b0;
			pin_low_r  <= 1'b0;
		end else if (ce) begin
			alert_oe_r <= alert_en && alert_cond;
			pin_low_r  <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence seq_addr_end;
		ce && state_r == SSF_ADDR && byte_end && !tmo_c;
	endsequence
	sequence seq_master_nack;
		ce && state_r == SSF_ACKR && scl_rise && sda_f && !stop_c;
	endsequence

	// RL1 drive changes follow fall or bus events
	chk_drive_timing: // RL1
	assert property (ce && $changed(sda_oe_r) |->
		$past(scl_fall) || $past(start_c) ||
		$past(stop_c) || $past(tmo_c))
		else $error("data drive changed off a falling edge");
	// RL2 no counting outside a transaction
	chk_count_window: // RL2
	assert property (ce && !in_txn_r |=> lowcnt_r == '0)
		else $error("clock-low counted outside a transaction");
	// RL3 timeout releases data and idles
	chk_timeout_release: // RL3
	assert property (ce && in_txn_r && !scl_f &&
		lowcnt_r == TMO_CYCLES - 1'b1 |=>
		tmo_r && !sda_oe_r && state_r == SSF_IDLE)
		else $error("timeout did not reset the interface");
	// RL5 one released, zero driven low
	chk_read_bits: // RL5
	assert property (ce && state_r == SSF_READ && scl_fall && !byte_end &&
		!start_c && !stop_c && !tmo_c |=> sda_oe_r == !$past(shift_r[SSF_NEXT]))
		else $error("transmitted bit driven wrongly");
	// RL8 mismatched address gets no acknowledge
	chk_addr_reject: // RL8
	assert property (seq_addr_end ##0 !addr_hit |=>
		!sda_oe_r && state_r == SSF_WAIT)
		else $error("acknowledged a foreign address");
	// RL16 matching address acknowledged
	chk_addr_ack: // RL16
	assert property (seq_addr_end ##0 addr_hit |=>
		sda_oe_r && state_r == SSF_ACKA)
		else $error("matching address not acknowledged");
	// RL17 no-ack stops the transmitter
	chk_nack_stop: // RL17
	assert property (seq_master_nack |=> state_r == SSF_WAIT ##1
		(!sda_oe_r throughout (state_r == SSF_WAIT)[*2]))
		else $error("kept transmitting after no-ack");
	// RL18 idle bus ignored until start
	chk_ignore_idle: // RL18
	assert property (ce && state_r == SSF_IDLE && !start_c |=>
		state_r == SSF_IDLE && !sda_oe_r)
		else $error("left idle without a start");
	// RL10 RL12 power-up state
	chk_powerup: // RL12
	assert property (ce && pu_cnt_r == PU_CYCLES - 1'b1 |=>
		temp_valid_r && ts_convert_r && mem_standby_r)
		else $error("temperature not valid in time");
endmodule

// ### rtl/ssf_pkg.sv
// shared constants and types of the smbus slave front end
package ssf_pkg;

	// system clock: 40 MHz
	localparam int SSF_CLK_PERIOD_NS = 25;
	localparam int SSF_NS_PER_MS     = 1000000;

	// widest input pulse that must be rejected, and the agree count
	localparam int SSF_GLITCH_NS  = 50;
	localparam int SSF_GLITCH_CYC =
		(SSF_GLITCH_NS + SSF_CLK_PERIOD_NS - 1) / SSF_CLK_PERIOD_NS;
	localparam int SSF_HOLD_CYC   = SSF_GLITCH_CYC + 1;

	// clock-low timeout, chosen inside the 25 ms to 35 ms window
	localparam int SSF_TMO_MS  = 30;
	localparam int SSF_TMO_CYC =
		SSF_TMO_MS * SSF_NS_PER_MS / SSF_CLK_PERIOD_NS;
	localparam int SSF_TMO_W   = 21;
	localparam logic [SSF_TMO_W-1:0] SSF_TMO_DEF = SSF_TMO_W'(SSF_TMO_CYC);

	// latest time for the first valid temperature result
	localparam int SSF_PU_MS  = 100;
	localparam int SSF_PU_CYC = SSF_PU_MS * SSF_NS_PER_MS / SSF_CLK_PERIOD_NS;
	localparam int SSF_PU_W   = 22;
	localparam logic [SSF_PU_W-1:0] SSF_PU_DEF = SSF_PU_W'(SSF_PU_CYC);

	// address byte layout and function preambles
	localparam logic [3:0] SSF_BYTE_BITS = 4'h8;
	localparam logic [3:0] SSF_PRE_TS    = 4'h3;
	localparam logic [3:0] SSF_PRE_MEM   = 4'hA;
	localparam int SSF_PRE_HI = 7;
	localparam int SSF_PRE_LO = 4;
	localparam int SSF_SEL_HI = 3;
	localparam int SSF_SEL_LO = 1;
	localparam int SSF_RW_BIT = 0;
	localparam int SSF_MSB    = 7;
	localparam int SSF_NEXT   = 6;

	// receive buffer shape and pin reset levels
	localparam int   SSF_FIFO_W   = 8;
	localparam int   SSF_FIFO_D   = 16;
	localparam logic SSF_BUS_IDLE = 1'b1;
	localparam logic SSF_SEL_RST  = 1'b0;

	// byte engine states
	typedef enum logic [2:0] {
		SSF_IDLE  = 3'h0,
		SSF_ADDR  = 3'h1,
		SSF_ACKA  = 3'h2,
		SSF_WRITE = 3'h3,
		SSF_ACKW  = 3'h4,
		SSF_READ  = 3'h5,
		SSF_ACKR  = 3'h6,
		SSF_WAIT  = 3'h7
	} ssf_state_type;

endpackage

// ### rtl/ssf_stream_if.sv
// valid/ready byte stream between the front end and its buffer
`timescale 1ns/10ps
interface ssf_stream_if #(
	parameter int W = 8
);
	logic         valid; // word offered
	logic         ready; // word can be taken
	logic [W-1:0] data;  // the word
	// producer side
	modport src (output valid, output data, input ready);
	// consumer side
	modport snk (input valid, input data, output ready);
endinterface

// ### rtl/ssf_filt.sv
// pin synchroniser with glitch rejection
`timescale 1ns/10ps
module ssf_filt #(
	parameter int   HOLD    = 3,
	parameter logic RST_VAL = 1'b1
) (
	// clock and control
	input  wire logic clock,
	input  wire logic ce,
	input  wire logic rst,
	// raw pin and clean level
	input  wire logic pin,
	output logic      level
);
	localparam int CW = $clog2(HOLD + 1);

	logic          s1_r;  // first sync stage
	logic          s2_r;  // second sync stage
	logic          s3_r;  // third sync stage
	logic [CW-1:0] cnt_r; // cycles the new value has been agreed
	logic          lvl_r; // accepted level

	assign level = lvl_r;

	// three stage synchroniser
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else if (ce) begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// RL4 agreement counter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (ce) begin
			if (s2_r != s3_r || s3_r == lvl_r) begin
				cnt_r <= '0;
			end else if (cnt_r != CW'(HOLD - 1)) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// RL4 accept only long pulses
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lvl_r <= RST_VAL;
		end else if (ce && s2_r == s3_r && s3_r != lvl_r &&
			cnt_r == CW'(HOLD - 1)) begin
			lvl_r <= s3_r;
		end
	end

	// RL4 level moves only after full hold
	chk_glitch_hold: // RL4
	assert property (@(posedge clock) disable iff (rst)
		$changed(lvl_r) |-> $past(cnt_r) == CW'(HOLD - 1))
		else $error("level changed before the hold count");
endmodule

// ### rtl/ssf_fifo.sv
// receive byte buffer with valid/ready on both sides
`timescale 1ns/10ps
module ssf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and control
	input  wire logic clock,
	input  wire logic ce,
	input  wire logic rst,
	// filling and draining sides
	ssf_stream_if.snk wr,
	ssf_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW-1:0]    wp_r;        // write pointer
	logic [AW-1:0]    rp_r;        // read pointer
	logic [AW:0]      cnt_r;       // words held
	logic             push;        // word taken in
	logic             pop;         // word handed out

	// honest full and empty
	assign wr.ready = (cnt_r != (AW + 1)'(DEPTH));
	assign rd.valid = (cnt_r != '0);
	assign rd.data  = mem[rp_r];
	assign push     = ce && wr.valid && wr.ready;
	assign pop      = ce && rd.valid && rd.ready;

	// storage write
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp_r] <= wr.data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// ### dv/ssf_host_model.sv
// host bus master model: makes serial clock, start and stop
`timescale 1ns/10ps
module ssf_host_model #(
	parameter int HALF = 20 // scl half period in system clocks
) (
	// system clock
	input  wire logic clock,
	// bus lines, sda_low high while host pulls data low
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// bus idle, both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// wait whole system clocks, moving at the falling edge
	task automatic w(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic start();
		sda_low = 1'b0;
		w(HALF / 4);
		scl = 1'b1;
		w(HALF / 2);
		sda_low = 1'b1;
		w(HALF / 2);
		scl = 1'b0;
		w(HALF / 2);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		w(HALF / 2);
		scl = 1'b1;
		w(HALF / 2);
		sda_low = 1'b0;
		w(HALF);
	endtask
	// one bit at 1 MHz, data moved only while clock low
	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		w(HALF / 2);
		scl = 1'b1;
		w(HALF / 2);
		r = sda;
		w(HALF / 2);
		scl = 1'b0;
		w(HALF / 2);
	endtask
	// byte msb first, ninth bit is the ack slot
	task automatic byte_x(input logic [7:0] d, input logic nb,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(nb, ack);
		ack = !ack;
	endtask
	// 50 ns low pulse on data while clock high
	task automatic glitch();
		sda_low = 1'b1;
		w(2);
		sda_low = 1'b0;
	endtask
	// clock held low outside any transaction
	task automatic hold_low(input int n);
		scl = 1'b0;
		w(n);
		scl = 1'b1;
		w(HALF);
	endtask
endmodule

// ### dv/ssf_top_tb_top.sv
// self-checking bench of the two-wire slave front end
`timescale 1ns/10ps
module ssf_top_tb_top;
	import ssf_pkg::*;
	localparam int TMO = 200; // shortened clock-low timeout
	localparam int PU  = 50;  // shortened power-up delay
	logic       clock, rst, scl, sda_low, sda, sda_oe, ack, r;
	logic       alert_cond, alert_en, alert_oe, rx_valid, rx_ready;
	logic       tx_req, tmo_p, start_p, ts_cv, mem_sb, temp_v;
	logic       ce, stop_p, sda_o, alert_o;
	logic [2:0] sel;
	logic [2:0] fl; // sensor, memory and read flags
	logic [7:0] tx_data, rx_data, q, d, a;
	logic [7:0] fq[$]; // bytes expected out of the buffer
	int         n_fail = 0, n_checks = 0, n_start = 0, n_tmo = 0, i, m;
	int         n_stop = 0, n_txr = 0;
	// wired-and data line with pull-up
	assign sda = !(sda_low || sda_oe);
	ssf_top #(.TMO_CYCLES(21'(TMO)), .PU_CYCLES(22'(PU))) DUT (
		.clock(clock), .ce(ce), .rst(rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
		.sel_pin0(sel[0]), .sel_pin1(sel[1]), .sel_pin2(sel[2]),
		.alert_cond(alert_cond), .alert_en(alert_en),
		.alert_out(alert_o), .alert_oe(alert_oe),
		.tx_data(tx_data), .tx_req(tx_req), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .addr_ts(fl[2]),
		.addr_mem(fl[1]), .read_mode(fl[0]), .start_seen(start_p),
		.stop_seen(stop_p), .timeout(tmo_p), .ts_convert(ts_cv),
		.mem_standby(mem_sb), .temp_valid(temp_v));
	ssf_host_model host (.clock(clock), .scl(scl), .sda_low(sda_low),
		.sda(sda));
	// 40 MHz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// count start, stop, timeout and byte load pulses
	always @(posedge clock) begin
		n_start <= n_start + 32'(start_p);
		n_tmo <= n_tmo + 32'(tmo_p);
		n_stop <= n_stop + 32'(stop_p);
		n_txr <= n_txr + 32'(tx_req);
	end
	// compare one value
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// take one received byte
	task automatic pop(input logic [7:0] e);
		repeat (3) @(negedge clock);
		chk(rx_valid, 1'b1);
		chk(rx_data, e);
		rx_ready = 1'b1;
		@(negedge clock);
		rx_ready = 1'b0;
	endtask
	// expected {sensor, memory, read} flags after an address byte
	function automatic logic [7:0] exp_part(input logic [3:0] p,
		input logic hit, input logic rd);
		return {5'h00, hit && p == SSF_PRE_TS, hit && p == SSF_PRE_MEM,
			rd};
	endfunction
	// address with preamble p and select s, then one byte if acked
	task automatic wr(input logic [3:0] p, input logic [2:0] s,
		input logic exp);
		int nst; // stop pulses seen before this stop
		host.start();
		host.byte_x({p, s, 1'b0}, 1'b1, q, ack);
		chk(ack, exp);
		chk(fl, exp_part(p, exp, 1'b0));
		d = 8'($urandom);
		if (exp) begin
			host.byte_x(d, 1'b1, q, ack);
			chk(ack, 1'b1);
		end
		nst = n_stop;
		host.stop();
		chk(8'(n_stop - nst), 8'h01);
		if (exp)
			pop(d);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// cut a hang short
	initial begin
		repeat (40000) @(posedge clock);
		n_fail++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		void'($urandom(70118));
		// select pins at plain logic levels only
		sel = 3'($urandom);
		ce = 1'b1;
		{alert_cond, alert_en, rx_ready, tx_data} = '0;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		chk(ts_cv & mem_sb, 1'b1);
		repeat (PU - 1) @(negedge clock);
		chk(temp_v, 1'b0);
		repeat (1) @(negedge clock);
		chk(temp_v, 1'b1);
		for (i = 0; i < 20; i++) begin
			{alert_en, alert_cond} = 2'($urandom);
			@(negedge clock);
			chk(alert_oe, alert_en & alert_cond);
		end
		// enable low freezes the alert register
		{alert_en, alert_cond} = 2'b00;
		@(negedge clock);
		ce = 1'b0;
		{alert_en, alert_cond} = 2'b11;
		repeat (3) @(negedge clock);
		chk(alert_oe, 1'b0);
		ce = 1'b1;
		@(negedge clock);
		chk(alert_oe, 1'b1);
		$display("test power-up and alert done");
		wr(SSF_PRE_TS, sel, 1'b1);
		wr(SSF_PRE_MEM, sel, 1'b1);
		wr(SSF_PRE_TS, sel ^ 3'(1 + $urandom % 7), 1'b0);
		wr(4'h5, sel, 1'b0);
		$display("test address match done");
		d = 8'($urandom);
		tx_data = d;
		m = n_txr;
		host.start();
		host.byte_x({SSF_PRE_MEM, sel, 1'b1}, 1'b1, q, ack);
		chk(ack, 1'b1);
		chk(fl, exp_part(SSF_PRE_MEM, 1'b1, 1'b1));
		host.byte_x(8'hFF, 1'b0, q, ack);
		chk(q, d);
		chk({sda_o, alert_o}, 8'h00);
		// second byte is loaded; a load after no-ack would drive low
		tx_data = 8'h00;
		host.byte_x(8'hFF, 1'b1, q, ack);
		chk(q, d);
		chk(sda_oe, 1'b0);
		host.stop();
		chk(8'(n_txr - m), 8'h02);
		$display("test read done");
		host.start();
		host.byte_x({SSF_PRE_MEM, sel, 1'b0}, 1'b1, q, ack);
		// sixteen buffer words plus the output register take 17 bytes
		for (i = 0; i < 18; i++) begin
			d = 8'($urandom);
			host.byte_x(d, 1'b1, q, ack);
			chk(ack, i < 17);
			if (i < 17)
				fq.push_back(d);
		end
		host.stop();
		for (i = 0; i < 17; i++)
			pop(fq.pop_front());
		chk(rx_valid, 1'b0);
		$display("test buffer full done");
		m = n_start;
		host.glitch();
		host.w(20);
		chk(8'(n_start - m), 8'h00);
		m = n_tmo;
		host.hold_low(TMO + 20);
		chk(8'(n_tmo - m), 8'h00);
		a = {SSF_PRE_TS, sel, 1'b0};
		host.start();
		for (i = 7; i >= 0; i--)
			host.bitx(a[i], r);
		chk(sda_oe, 1'b1);
		host.w(TMO + 20);
		chk(8'(n_tmo - m), 8'h01);
		chk(sda_oe, 1'b0);
		wr(SSF_PRE_TS, sel, 1'b1);
		$display("test glitch and timeout done");
		rst = 1'b1;
		@(negedge clock);
		chk({ts_cv, mem_sb, temp_v, sda_oe}, 8'h0C);
		rst = 1'b0;
		host.w(20);
		wr(SSF_PRE_MEM, sel, 1'b1);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule
